// ---- inc/usart_pkg.sv ----
// Purpose: shared constants and types of the serial transceiver
// Assumes: 8-bit processor port, control words one byte wide
// Notes:   field positions of mode, command and status words live here
package usart_pkg;
  // mode word fields
  localparam int MODE_RATE_LSB    = 0;
  localparam int MODE_LEN_LSB     = 2;
  localparam int MODE_PAR_EN      = 4;
  localparam int MODE_PAR_EVEN    = 5;
  localparam int MODE_STOP_LSB    = 6;
  localparam int MODE_EXT_SYNC    = 6;
  localparam int MODE_SINGLE_SYNC = 7;
  localparam logic [1:0] RATE_SYNC = 2'h0;
  localparam logic [1:0] RATE_X1   = 2'h1;
  localparam logic [1:0] RATE_X16  = 2'h2;
  localparam logic [1:0] RATE_X64  = 2'h3;
  localparam logic [1:0] STOP_1    = 2'h1;
  localparam logic [1:0] STOP_15   = 2'h2;
  localparam logic [1:0] STOP_2    = 2'h3;
  localparam logic [6:0] DIV_X1    = 7'h01;
  localparam logic [6:0] DIV_X16   = 7'h10;
  localparam logic [6:0] DIV_X64   = 7'h40;
  // command word fields
  localparam int CMD_TX_EN    = 0;
  localparam int CMD_RX_EN    = 2;
  localparam int CMD_BREAK    = 3;
  localparam int CMD_ERR_CLR  = 4;
  localparam int CMD_SOFT_RST = 6;
  localparam int CMD_HUNT     = 7;
  // status word fields
  localparam int ST_TX_EMPTY  = 0;
  localparam int ST_RX_READY  = 1;
  localparam int ST_DRAINED   = 2;
  localparam int ST_PARITY    = 3;
  localparam int ST_OVERRUN   = 4;
  localparam int ST_FRAMING   = 5;
  localparam int ST_SYNC      = 6;
  localparam int ST_TX_BUSY   = 7;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET  = 8'h00;
  localparam logic [7:0] SYNC_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE  = 8'h00;
  typedef enum logic [1:0] {SEQ_MODE, SEQ_SYNC1, SEQ_SYNC2, SEQ_CMD} seq_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_t;
  typedef enum logic [1:0] {SY_HUNT, SY_HUNT2, SY_LOCKED} sync_t;
endpackage

// ---- rtl/bit_sync.sv ----
// Purpose: two-stage synchroniser with edge pulses for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   edges are taken behind the second stage only
`timescale 1ns/10ps
module bit_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // pins and results
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign q    = s2;
  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;
endmodule

// ---- rtl/sync_async_serial_usart.sv ----
// Purpose: sync/async serial transceiver behind an 8-bit processor port
// Assumes: bit clocks far slower than clk (at least 4 clk per half period)
// Notes:   bit clocks are sampled, not used as clocks
//
// Summary of operation
// RQ1 - mode word sets rate factor, length, stop bits, sync mode, pin, parity
// RQ2 - tx_ready high when a character fits; a data write drops it
// RQ3 - rx_ready rises on a finished character; data read clears it
// RQ4 - software does a dummy read after power-on or receive re-enable
// RQ5 - no character starts before transmit enable is set and CTS low
// RQ6 - software sends two to four control words after every reset
// RQ7 - three 00 or two 80 writes then 40 reinitialise the device
// RQ8 - write after sync mode word is a sync character, then commands
// RQ9 - commands accepted any time; one bit returns to mode word entry
// RQ10 - async frame is start, data, optional parity, then stop bits
// RQ11 - async bits change on falling bit clock, every 1, 16 or 64
// RQ12 - serial_out marks when idle and is held low for break
// RQ13 - falling serial_in starts a bit, confirmed low at centre
// RQ14 - receiver samples on the falling edge of the receive clock
// RQ15 - parity mismatch flags parity error; framing error in async only
// RQ16 - unread character is overwritten and overrun flag set
// RQ17 - one command bit clears all error flags; errors never halt
// RQ18 - sync transmit shifts each falling edge, fills with sync chars
// RQ19 - tx_drained while filling with sync, cleared by next data write
// RQ20 - hunt compares each bit against sync chars, raises sync_found
// RQ21 - external sync_found input high gives character sync
// RQ22 - sync mode checks parity out of hunt even with receive off
// RQ23 - read with control select high returns the status word
// RQ24 - fault_flag_clear_bit in a command clears error flags
`timescale 1ns/10ps
module sync_async_serial_usart
  import usart_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // processor port
  input  wire logic       control_or_data_select,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // handshake pins
  output logic            tx_ready,
  output logic            rx_ready,
  output logic            tx_drained,
  // serial side
  input  wire logic       tx_bit_clock,
  input  wire logic       rx_bit_clock,
  input  wire logic       serial_in,
  input  wire logic       cts_n,
  output logic            serial_out,
  // sync-found pin, two-way
  input  wire logic       sync_found_in,
  output logic            sync_found_out,
  output logic            sync_found_oe_n
);
  logic [4:0]  pin_q;
  logic [4:0]  pin_rise;
  logic [4:0]  pin_fall;
  logic        tx_edge;
  logic        rx_edge;
  logic        rxd;
  logic        rxd_fall;
  logic        cts_s;
  logic        ext_rise;
  seq_t        seq;
  logic [7:0]  mode;
  logic [7:0]  cmd;
  logic [7:0]  sync1;
  logic [7:0]  sync2;
  logic        soft_rst;
  logic        ctl_wr;
  logic        cmd_wr;
  logic        data_wr;
  logic        data_rd;
  logic        stat_rd;
  logic        err_clr;
  logic        hunt_go;
  logic [1:0]  rate;
  logic [1:0]  clen;
  logic [1:0]  stop;
  logic        is_sync;
  logic        par_en;
  logic        par_even;
  logic        ext_sync;
  logic        single_sync;
  logic [3:0]  nbits;
  logic [3:0]  last_idx;
  logic [7:0]  mask;
  logic [6:0]  div;
  logic [6:0]  half;
  logic [7:0]  tx_buf;
  logic [7:0]  tx_src;
  logic        tx_full;
  logic        tx_busy;
  logic        tx_primed;
  logic        tx_pick2;
  logic        tx_fill;
  logic        tx_go;
  logic        tx_bit_end;
  logic        tx_start;
  logic        tx_par;
  logic [11:0] tx_sh;
  logic [11:0] next_frame;
  logic [3:0]  tx_left;
  logic [3:0]  next_count;
  logic [6:0]  tx_div;
  logic [6:0]  tx_bit_len;
  rx_t         rx_st;
  sync_t       sy;
  logic [6:0]  rx_cnt;
  logic [3:0]  rx_bitn;
  logic [8:0]  rx_sh;
  logic [8:0]  next_sh;
  logic [7:0]  rx_win;
  logic [7:0]  next_win;
  logic [7:0]  rx_char;
  logic [7:0]  rx_buf;
  logic        rx_done;
  logic        rx_stop_bad;
  logic        sync_hit;
  logic        rx_load;
  logic        par_bad;
  logic        pe;
  logic        oe;
  logic        fe;
  logic [7:0]  status;

  function automatic logic [6:0] div_of(input logic [1:0] r);
    case (r)
      RATE_X16: div_of = DIV_X16;
      RATE_X64: div_of = DIV_X64;
      default:  div_of = DIV_X1;
    endcase
  endfunction

  function automatic logic [7:0] len_mask(input logic [1:0] l);
    len_mask = 8'hFF >> (2'h3 - l);
  endfunction

  function automatic logic par_of(input logic [7:0] d, input logic [1:0] l,
                                  input logic even);
    par_of = (^(d & len_mask(l))) ^ ~even;
  endfunction

  // bit clocks, data and handshake pins all come from outside clk
  bit_sync #(.W(5)) u_pins (
    .clk  (clk),
    .rstn (rstn),
    .d    ({sync_found_in, cts_n, serial_in, rx_bit_clock, tx_bit_clock}),
    .q    (pin_q),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  assign tx_edge  = pin_fall[0];
  // RQ14 receive sample edge
  assign rx_edge  = pin_fall[1];
  assign rxd      = pin_q[2];
  assign rxd_fall = pin_fall[2];
  assign cts_s    = pin_q[3];
  assign ext_rise = pin_rise[4];

  assign ctl_wr  = wr & control_or_data_select;
  assign data_wr = wr & ~control_or_data_select;
  assign data_rd = rd & ~control_or_data_select;
  assign stat_rd = rd & control_or_data_select;
  assign cmd_wr  = ctl_wr & (seq == SEQ_CMD);
  // RQ17 RQ24 error clear strobe
  assign err_clr = cmd_wr & wdata[CMD_ERR_CLR];
  assign hunt_go = cmd_wr & wdata[CMD_HUNT];

  // RQ1 mode word decode
  always_comb begin
    rate        = mode[MODE_RATE_LSB +: 2];
    clen        = mode[MODE_LEN_LSB +: 2];
    stop        = mode[MODE_STOP_LSB +: 2];
    is_sync     = rate == RATE_SYNC;
    par_en      = mode[MODE_PAR_EN];
    par_even    = mode[MODE_PAR_EVEN];
    ext_sync    = is_sync & mode[MODE_EXT_SYNC];
    single_sync = mode[MODE_SINGLE_SYNC];
    nbits       = 4'h5 + {2'h0, clen};
    last_idx    = nbits - 4'h1 + {3'h0, par_en};
    mask        = len_mask(clen);
    div         = is_sync ? DIV_X1 : div_of(rate);
    half        = (div == DIV_X1) ? DIV_X1 : (div >> 1);
  end

  // RQ6 RQ7 RQ8 RQ9 control word sequencing
  always_ff @(posedge clk) begin
    if (!rstn) begin
      seq   <= SEQ_MODE;
      mode  <= MODE_RESET;
      cmd   <= CMD_RESET;
      sync1 <= SYNC_RESET;
      sync2 <= SYNC_RESET;
    end else if (ctl_wr) begin
      case (seq)
        SEQ_MODE: begin
          mode <= wdata;
          seq  <= (wdata[MODE_RATE_LSB +: 2] == RATE_SYNC) ? SEQ_SYNC1
                                                            : SEQ_CMD;
        end
        SEQ_SYNC1: begin
          sync1 <= wdata;
          seq   <= single_sync ? SEQ_CMD : SEQ_SYNC2;
        end
        SEQ_SYNC2: begin
          sync2 <= wdata;
          seq   <= SEQ_CMD;
        end
        SEQ_CMD: begin
          if (wdata[CMD_SOFT_RST]) begin
            seq <= SEQ_MODE;
            cmd <= CMD_RESET;
          end else begin
            cmd <= wdata;
          end
        end
        default: seq <= SEQ_MODE;
      endcase
    end
  end

  // sequencer resets itself at once so a mode word may follow directly
  always_ff @(posedge clk) begin
    if (!rstn) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= cmd_wr & wdata[CMD_SOFT_RST];
    end
  end

  // RQ5 transmit gate
  assign tx_go      = cmd[CMD_TX_EN] & ~cts_s;
  assign tx_bit_len = (tx_left == 4'h1 && stop == STOP_15 && !is_sync)
                      ? half : div;
  // RQ11 bit period count
  assign tx_bit_end = tx_busy & tx_edge & (tx_div == tx_bit_len - 7'h01);
  // RQ18 fill when empty
  assign tx_fill    = is_sync & tx_primed & ~tx_full;
  assign tx_start   = tx_edge & tx_go & (tx_full | tx_fill) &
                      (~tx_busy | (tx_bit_end & (tx_left == 4'h1)));
  assign tx_src     = tx_full ? tx_buf : (tx_pick2 ? sync2 : sync1);
  assign tx_par     = par_en & par_of(tx_src, clen, par_even);

  // RQ10 frame layout
  always_comb begin
    if (is_sync) begin
      next_frame = {4'h0, tx_src & mask} | ({11'h000, tx_par} << nbits);
      next_count = nbits + {3'h0, par_en};
    end else begin
      next_frame = (12'hFFF << (nbits + 4'h1 + {3'h0, par_en})) |
                   {3'h0, tx_src & mask, 1'b0} |
                   ({11'h000, tx_par} << (nbits + 4'h1));
      next_count = nbits + 4'h1 + {3'h0, par_en} +
                   ((stop == STOP_2 || stop == STOP_15) ? 4'h2 : 4'h1);
    end
  end

  // RQ11 RQ18 shifter on falling bit clock
  always_ff @(posedge clk) begin
    if (!rstn || soft_rst) begin
      tx_busy   <= 1'b0;
      tx_sh     <= 12'hFFF;
      tx_left   <= 4'h0;
      tx_div    <= 7'h00;
      tx_primed <= 1'b0;
      tx_pick2  <= 1'b0;
    end else if (tx_start) begin
      tx_busy <= 1'b1;
      tx_sh   <= next_frame;
      tx_left <= next_count;
      tx_div  <= 7'h00;
      if (tx_full) begin
        tx_primed <= tx_primed | is_sync;
      end else begin
        tx_pick2 <= ~single_sync & ~tx_pick2;
      end
    end else if (tx_bit_end) begin
      tx_sh   <= {1'b1, tx_sh[11:1]};
      tx_left <= tx_left - 4'h1;
      tx_div  <= 7'h00;
      if (tx_left == 4'h1) begin
        tx_busy <= 1'b0;
      end
    end else if (tx_busy && tx_edge) begin
      tx_div <= tx_div + 7'h01;
    end
  end

  // a write into a full buffer replaces the waiting character
  always_ff @(posedge clk) begin
    if (!rstn || soft_rst) begin
      tx_buf     <= 8'h00;
      tx_full    <= 1'b0;
      tx_drained <= 1'b0;
    end else begin
      if (data_wr) begin
        tx_buf  <= wdata;
        tx_full <= 1'b1;
      end else if (tx_start && tx_full) begin
        tx_full <= 1'b0;
      end
      // RQ19 drained flag
      if (tx_start && tx_fill) begin
        tx_drained <= 1'b1;
      end else if (data_wr) begin
        tx_drained <= 1'b0;
      end
    end
  end

  // RQ2 ready pin
  always_ff @(posedge clk) begin
    if (!rstn || soft_rst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= tx_go & ~tx_full & ~data_wr;
    end
  end

  // RQ12 marking and break
  always_ff @(posedge clk) begin
    if (!rstn || soft_rst) begin
      serial_out <= 1'b1;
    end else if (cmd[CMD_BREAK]) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= tx_busy ? tx_sh[0] : 1'b1;
    end
  end

  // RQ1 sync pin direction
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_found_oe_n <= 1'b1;
    end else begin
      sync_found_oe_n <= ~(is_sync & ~ext_sync);
    end
  end

  always_comb begin
    next_sh = rx_sh;
    if (rx_bitn <= 4'h8) begin
      next_sh[rx_bitn] = rxd;
    end
  end
  assign next_win = {rxd, rx_win[7:1]};
  assign rx_char  = rx_sh[7:0] & mask;
  assign par_bad  = par_en & (rx_sh[nbits] != par_of(rx_char, clen, par_even));
  // RQ22 sync keeps checking parity
  assign rx_load  = rx_done & (~is_sync | cmd[CMD_RX_EN]);

  always_ff @(posedge clk) begin
    if (!rstn || soft_rst) begin
      rx_st       <= RX_IDLE;
      sy          <= SY_HUNT;
      rx_cnt      <= 7'h00;
      rx_bitn     <= 4'h0;
      rx_sh       <= 9'h000;
      rx_win      <= 8'h00;
      rx_done     <= 1'b0;
      rx_stop_bad <= 1'b0;
      sync_hit    <= 1'b0;
    end else begin
      rx_done  <= 1'b0;
      sync_hit <= 1'b0;
      if (is_sync) begin
        rx_st <= RX_IDLE;
        if (hunt_go && !ext_sync) begin
          sy <= SY_HUNT;
        // RQ21 external sync
        end else if (ext_sync && ext_rise) begin
          sy       <= SY_LOCKED;
          rx_bitn  <= 4'h0;
          sync_hit <= 1'b1;
        end else if (rx_edge) begin
          rx_win <= next_win;
          case (sy)
            // RQ20 sync hunt compare
            SY_HUNT: begin
              if (!ext_sync &&
                  (next_win >> (2'h3 - clen)) == (sync1 & mask)) begin
                sy       <= single_sync ? SY_LOCKED : SY_HUNT2;
                sync_hit <= single_sync;
                rx_bitn  <= 4'h0;
              end
            end
            default: begin
              rx_sh <= next_sh;
              if (rx_bitn == last_idx) begin
                rx_bitn <= 4'h0;
                if (sy == SY_HUNT2) begin
                  if ((next_sh[7:0] & mask) == (sync2 & mask)) begin
                    sy       <= SY_LOCKED;
                    sync_hit <= 1'b1;
                  end else begin
                    sy <= SY_HUNT;
                  end
                end else begin
                  rx_done <= 1'b1;
                end
              end else begin
                rx_bitn <= rx_bitn + 4'h1;
              end
            end
          endcase
        end
      end else begin
        sy <= SY_HUNT;
        case (rx_st)
          RX_IDLE: begin
            if (cmd[CMD_RX_EN] && rxd_fall) begin
              rx_st  <= RX_START;
              rx_cnt <= 7'h00;
            end
          end
          // RQ13 start bit centre check
          RX_START: begin
            if (rx_edge) begin
              if (rx_cnt == half - 7'h01) begin
                rx_cnt  <= 7'h00;
                rx_bitn <= 4'h0;
                rx_st   <= rxd ? RX_IDLE : RX_BITS;
              end else begin
                rx_cnt <= rx_cnt + 7'h01;
              end
            end
          end
          RX_BITS: begin
            if (rx_edge) begin
              if (rx_cnt == div - 7'h01) begin
                rx_cnt <= 7'h00;
                if (rx_bitn == last_idx + 4'h1) begin
                  rx_st       <= RX_IDLE;
                  rx_done     <= 1'b1;
                  rx_stop_bad <= ~rxd;
                end else begin
                  rx_sh   <= next_sh;
                  rx_bitn <= rx_bitn + 4'h1;
                end
              end else begin
                rx_cnt <= rx_cnt + 7'h01;
              end
            end
          end
          default: rx_st <= RX_IDLE;
        endcase
      end
    end
  end

  // flags: a setting event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn || soft_rst) begin
      rx_buf         <= 8'h00;
      rx_ready       <= 1'b0;
      pe             <= 1'b0;
      oe             <= 1'b0;
      fe             <= 1'b0;
      sync_found_out <= 1'b0;
    end else begin
      if (rx_load) begin
        rx_buf <= rx_char;
      end
      // RQ3 ready set and clear
      if (rx_load) begin
        rx_ready <= 1'b1;
      end else if (data_rd) begin
        rx_ready <= 1'b0;
      end
      // RQ16 overrun
      if (rx_load && rx_ready && !data_rd) begin
        oe <= 1'b1;
      end else if (err_clr) begin
        oe <= 1'b0;
      end
      // RQ15 parity and framing
      if (rx_done && par_bad) begin
        pe <= 1'b1;
      end else if (err_clr) begin
        pe <= 1'b0;
      end
      if (rx_done && !is_sync && rx_stop_bad) begin
        fe <= 1'b1;
      end else if (err_clr) begin
        fe <= 1'b0;
      end
      // RQ20 status read clears
      if (sync_hit) begin
        sync_found_out <= 1'b1;
      end else if (stat_rd) begin
        sync_found_out <= 1'b0;
      end
    end
  end

  always_comb begin
    status              = 8'h00;
    status[ST_TX_EMPTY] = ~tx_full;
    status[ST_RX_READY] = rx_ready;
    status[ST_DRAINED]  = tx_drained;
    status[ST_PARITY]   = pe;
    status[ST_OVERRUN]  = oe;
    status[ST_FRAMING]  = fe;
    status[ST_SYNC]     = sync_found_out;
    status[ST_TX_BUSY]  = tx_busy;
  end

  // RQ23 status or data read
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= READ_IDLE;
    end else if (rd) begin
      rdata <= control_or_data_select ? status : rx_buf;
    end else begin
      rdata <= READ_IDLE;
    end
  end

  default clocking ast_cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // RQ2 ready drops
  AST_TX_READY_DROP: assert property (data_wr |=> !tx_ready) // RQ2
    else $error("tx_ready high after data write");
  // RQ3 ready rises
  AST_RX_READY_SET: assert property (rx_load |=> rx_ready) // RQ3
    else $error("rx_ready missing after character");
  // RQ3 read clears
  AST_RX_READY_CLR: assert property (data_rd && !rx_load |=> !rx_ready) // RQ3
    else $error("rx_ready survived data read");
  // RQ5 start gated
  AST_TX_GATE: assert property ($rose(tx_busy) |-> $past(tx_go)) // RQ5
    else $error("frame started without enable and CTS");
  // RQ12 break low
  AST_BREAK: assert property (cmd[CMD_BREAK] |=> !serial_out) // RQ12
    else $error("serial_out not low during break");
  // RQ15 no sync framing
  AST_NO_FE_SYNC: assert property ($rose(fe) |-> $past(!is_sync)) // RQ15
    else $error("framing error raised in sync mode");
  // RQ16 overrun set
  AST_OVR: assert property (rx_load && rx_ready && !data_rd |=> oe) // RQ16
    else $error("overrun not flagged");
  // RQ17 clear all
  AST_ERR_CLR: assert property (err_clr && !rx_done |=> !pe && !oe && !fe) // RQ17
    else $error("error flags not cleared");
  // RQ8 sync char next
  AST_SEQ_SYNC: assert property (ctl_wr && seq == SEQ_MODE &&
      wdata[MODE_RATE_LSB +: 2] == RATE_SYNC |=> seq == SEQ_SYNC1) // RQ8
    else $error("sync mode word not followed by sync entry");
  // RQ9 soft reset
  AST_SOFT_RST: assert property (cmd_wr && wdata[CMD_SOFT_RST] |=>
      seq == SEQ_MODE ##1 !tx_busy && serial_out) // RQ9
    else $error("internal reset did not return to mode entry");
  // RQ20 read clears
  AST_SYNC_CLR: assert property (stat_rd && !sync_hit |=> !sync_found_out) // RQ20
    else $error("sync_found not cleared by status read");

  COV_RX_CHAR: cover property (rx_load ##[1:300] data_rd);
  COV_SYNC_FILL: cover property (tx_start && tx_fill);
  COV_SYNC_LOCK: cover property (sync_hit && !ext_sync);
endmodule

// ---- tb/serial_peer.sv ----
// Purpose: remote serial station facing the transceiver link
// Assumes: 8 data bits; div bit clock periods per bit in both directions
// Notes:   line is read one fall after a change, clear of the output lag
`timescale 1ns/10ps
module serial_peer (
  // link clock and rate
  input  wire logic       bclk,
  input  wire logic [6:0] div,
  input  wire logic       listen,
  // serial lines
  input  wire logic       serial_out,
  output logic            serial_in
);
  logic [8:0] cap;
  event       got;
  initial serial_in = 1'b1;
  // capture data and first stop near their centres
  always begin
    @(negedge bclk);
    if (listen === 1'b1 && serial_out === 1'b0) begin
      repeat (div / 2) @(negedge bclk);
      for (int i = 0; i < 9; i++) begin
        repeat (div) @(negedge bclk);
        cap[i] = serial_out;
      end
      -> got;
    end
  end
  // low start, n bits lsb first, then marking; a low stop is allowed
  // changes on rising bclk so a falling-edge sample lands mid-bit
  task automatic send(input logic [9:0] bits, input int n);
    @(posedge bclk);
    serial_in <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      repeat (div) @(posedge bclk);
      serial_in <= (i < n) ? bits[i] : 1'b1;
    end
  endtask
endmodule

// ---- tb/sync_async_serial_usart_tb.sv ----
// Purpose: self-checking bench for the serial transceiver
// Assumes: 8-bit frames, bit clocks tied, free-running 200 ns
// Notes:   reads and frames are checked from queues by watcher processes
`timescale 1ns/10ps
module sync_async_serial_usart_tb import usart_pkg::*;;
  localparam logic [7:0] M8N1 = 8'h4D;
  localparam logic [7:0] M64 = 8'h8F;
  localparam logic [7:0] CMD_ON = 8'h15;
  logic clk, rstn, sel, wr, rd, bclk, serial_in, cts_n, listen, sync_in;
  logic [7:0] wdata, rdata;
  logic tx_ready, rx_ready, tx_drained, serial_out, rd_d, brk, sfo, sfo_n;
  logic [6:0] div;
  logic [15:0] rq[$], e, seed;
  logic [8:0] tq[$], t;
  int fail_count, compares;
  sync_async_serial_usart dut (.clk(clk), .rstn(rstn),
    .control_or_data_select(sel), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tx_ready(tx_ready), .rx_ready(rx_ready),
    .tx_drained(tx_drained), .tx_bit_clock(bclk), .rx_bit_clock(bclk),
    .serial_in(serial_in), .cts_n(cts_n), .serial_out(serial_out),
    .sync_found_in(sync_in), .sync_found_out(sfo), .sync_found_oe_n(sfo_n));
  serial_peer peer (.bclk(bclk), .div(div), .listen(listen),
    .serial_out(serial_out), .serial_in(serial_in));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    bclk = 1'b1;
    #7;
    forever #100 bclk = ~bclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr_c(input logic s, input logic [7:0] d);
    @(posedge clk);
    sel <= s;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_c(input logic s, input logic [7:0] m, input logic [7:0] v);
    @(posedge clk);
    sel <= s;
    rd <= 1'b1;
    rq.push_back({m, v});
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic tx_byte;
    for (int i = 0; i < 8000 && tx_ready !== 1'b1; i++) @(posedge clk);
    seed = lfsr(seed);
    tq.push_back({1'b1, seed[7:0]});
    wr_c(1'b0, seed[7:0]);
  endtask
  task automatic drain;
    for (int i = 0; i < 8000 && tq.size() != 0; i++) @(posedge clk);
    chk(tq.size() == 0, "frames sent");
  endtask
  task automatic rx_byte(input logic [7:0] d);
    peer.send({1'b1, d}, 9);
    for (int i = 0; i < 200 && rx_ready !== 1'b1; i++) @(posedge clk);
    chk(rx_ready === 1'b1, "rx_ready raised");
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // result appears in the cycle after the read strobe is taken
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d === 1'b1) begin
      e = rq.pop_front();
      chk((rdata & e[15:8]) === e[7:0], "read data");
    end
  end
  always @(peer.got) begin
    t = tq.pop_front();
    chk(peer.cap === t, "serial frame");
  end
  initial begin
    #400000;
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    wrap_up();
  end
  initial begin
    {rstn, sel, wr, rd, cts_n, sync_in, brk} = '0;
    {fail_count, compares} = '0;
    wdata = 8'h00;
    listen = 1'b1;
    div = 7'h01;
    seed = 16'hF319;
    repeat (8) @(posedge clk);
    chk(serial_out === 1'b1 && tx_ready === 1'b0, "reset idle");
    rstn <= 1'b1;
    wr_c(1'b1, M8N1);
    wr_c(1'b1, CMD_ON);
    rd_c(1'b0, 8'hFF, 8'h00);
    cts_n <= 1'b1;
    tx_byte();
    repeat (160) @(posedge clk);
    chk(serial_out === 1'b1 && tx_ready === 1'b0, "held by cts");
    cts_n <= 1'b0;
    drain();
    for (int k = 0; k < 3; k++) begin
      tx_byte();
      repeat (2) @(posedge clk);
      chk(k == 0 || tx_ready === 1'b0, "ready dropped");
    end
    drain();
    $display("test transmit done");
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      rx_byte(seed[7:0]);
      rd_c(1'b0, 8'hFF, seed[7:0]);
      repeat (2) @(posedge clk);
      chk(rx_ready === 1'b0, "rx_ready cleared");
    end
    rx_byte(8'hA5);
    rx_byte(8'h3C);
    rd_c(1'b1, 8'h10, 8'h10);
    rd_c(1'b0, 8'hFF, 8'h3C);
    peer.send({1'b0, 8'h5A}, 9);
    repeat (20) @(posedge clk);
    rd_c(1'b1, 8'h20, 8'h20);
    rd_c(1'b0, 8'hFF, 8'h5A);
    rx_byte(8'h96);
    rd_c(1'b0, 8'hFF, 8'h96);
    wr_c(1'b1, CMD_ON);
    rd_c(1'b1, 8'h38, 8'h00);
    $display("test receive done");
    listen <= 1'b0;
    wr_c(1'b1, CMD_ON | 8'h08);
    repeat (10) @(posedge clk);
    repeat (80) begin
      @(posedge clk);
      brk = brk | (serial_out !== 1'b0);
    end
    chk(brk === 1'b0, "break low");
    wr_c(1'b1, CMD_ON);
    repeat (40) @(posedge clk);
    chk(serial_out === 1'b1, "marking after break");
    listen <= 1'b1;
    $display("test break done");
    repeat (3) wr_c(1'b1, 8'h00);
    wr_c(1'b1, 8'h40);
    wr_c(1'b1, M64);
    repeat (8) @(posedge clk);
    chk(tx_ready === 1'b0, "mode taken after soft reset");
    div <= 7'h40;
    wr_c(1'b1, CMD_ON);
    tx_byte();
    drain();
    rx_byte(8'hC3);
    rd_c(1'b0, 8'hFF, 8'hC3);
    repeat (4) @(posedge clk);
    $display("test soft reset done");
    listen <= 1'b0;
    div <= 7'h01;
    wr_c(1'b1, 8'h40);
    wr_c(1'b1, 8'h8C);
    wr_c(1'b1, 8'h16);
    wr_c(1'b1, 8'h05);
    wr_c(1'b0, 8'h81);
    repeat (150) @(posedge clk);
    chk(tx_drained === 1'b1, "drained set");
    rd_c(1'b1, 8'h04, 8'h04);
    // write clear of the fill start so the clear is not outvoted
    @(negedge bclk);
    wr_c(1'b0, 8'h42);
    repeat (2) @(posedge clk);
    chk(tx_drained === 1'b0, "drained cleared");
    peer.send({2'h0, 8'h16}, 8);
    repeat (20) @(posedge clk);
    chk(sfo === 1'b1 && sfo_n === 1'b0, "sync found out");
    rd_c(1'b1, 8'h40, 8'h40);
    rd_c(1'b1, 8'h40, 8'h00);
    repeat (4) @(posedge clk);
    $display("test sync done");
    wrap_up();
  end
endmodule
